/* hw/level_sync.sv */
// Purpose: two-flop synchroniser for asynchronous levels
// Assumes: inputs are slow levels
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module level_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// ------------------------------------------------------------
	// per bit stages
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					meta_reg[i] <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta_reg[i] <= d[i];
					q[i] <= meta_reg[i];
				end
			end
		end
	endgenerate
endmodule

/* hw/spread_clock_gen.sv */
// Purpose: spread spectrum enable pulses for boost switching
// Assumes: run high while the boost converter is powered
// Notes: period is base plus a 5 bit lfsr value, mean near 2 MHz
`timescale 1ns/1ps
module spread_clock_gen
	import supply_mode_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	output logic tick
);
	logic [SPREAD_W-1:0] lfsr_reg;
	logic [SPREAD_W-1:0] lfsr_next;
	logic [6:0] cnt_reg;
	logic [6:0] period;
	wire period_done;

	// ------------------------------------------------------------
	// period selection
	// ------------------------------------------------------------
	// lfsr never holds zero, so periods span base+1 to base+31
	assign lfsr_next = {lfsr_reg[SPREAD_W-2:0], lfsr_reg[4] ^ lfsr_reg[2]};
	assign period = BOOST_BASE_CYC + {2'b00, lfsr_reg}; // [RULE17]
	assign period_done = (cnt_reg >= period - 7'h01);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lfsr_reg <= SPREAD_SEED;
			cnt_reg <= 7'h00;
			tick <= 1'b0;
		end else if (!run) begin
			cnt_reg <= 7'h00;
			tick <= 1'b0;
		end else if (period_done) begin
			lfsr_reg <= lfsr_next;
			cnt_reg <= 7'h00;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 7'h01;
			tick <= 1'b0;
		end
	end
endmodule

/* hw/supply_mode_pkg.sv */
// Purpose: shared constants and types for the supply mode sequencer
// Assumes: 100 MHz system clock
// Notes: register indices are local write addresses of the decoder port
package supply_mode_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int WAKE_TO_ACTIVE_TYP_US = 180;
	localparam int WAKE_TO_ACTIVE_MAX_US = 250;
	localparam int WAKE_TO_ACTIVE_TYP_CYC = WAKE_TO_ACTIVE_TYP_US * CLK_MHZ;
	localparam int WAKE_TO_ACTIVE_MAX_CYC = WAKE_TO_ACTIVE_MAX_US * CLK_MHZ;
	localparam int BOOST_AVG_KHZ = 2000;
	localparam int BOOST_MIN_KHZ = 800;
	localparam int BOOST_MAX_KHZ = 3200;
	localparam int BOOST_AVG_CYC = CLK_MHZ * 1000 / BOOST_AVG_KHZ;
	localparam int BOOST_SHORT_CYC = (CLK_MHZ * 1000 + BOOST_MAX_KHZ - 1)
		/ BOOST_MAX_KHZ;
	localparam int BOOST_LONG_CYC = CLK_MHZ * 1000 / BOOST_MIN_KHZ;
	localparam int SPREAD_W = 5;
	localparam logic [6:0] BOOST_BASE_CYC = 7'(BOOST_AVG_CYC - 16);

	// ------------------------------------------------------------
	// register indices on the write port
	// ------------------------------------------------------------
	localparam logic [2:0] IDX_BOOST_LEVEL = 3'h0;
	localparam logic [2:0] IDX_POWER_STATE = 3'h1;
	localparam logic [2:0] IDX_OUTPUT_ENABLE_MASK = 3'h2;
	localparam logic [2:0] IDX_TUNE_CODE_A = 3'h3;
	localparam int NUM_OUTPUTS = 3;

	// ------------------------------------------------------------
	// reset values and encodings
	// ------------------------------------------------------------
	localparam logic [3:0] BOOST_LEVEL_RST = 4'hb;
	localparam logic [2:0] OUTPUT_ENABLE_MASK_RST = 3'h0;
	localparam logic [7:0] TUNE_CODE_RST = 8'h00;
	localparam logic [7:0] TUNE_CODE_OFF = 8'h00;
	localparam logic [4:0] HV_MIN_VOLTS = 5'h09;
	localparam logic [1:0] PS_ACTIVE = 2'h0;
	localparam logic [1:0] PS_STARTUP = 2'h1;
	localparam logic [1:0] PS_LOW_POWER = 2'h2;
	localparam logic [1:0] PS_SHUTDOWN = 2'h3;
	localparam logic [SPREAD_W-1:0] SPREAD_SEED = 5'h01;

	typedef enum logic [1:0] {
		MODE_SHUTDOWN,
		MODE_STARTUP,
		MODE_ACTIVE,
		MODE_LOW_POWER
	} mode_t;

endpackage

/* hw/supply_mode_sequencer.sv */
// Purpose: operating mode sequencer for a three output tuning controller
// Assumes: serial framing decoded elsewhere into one-cycle writes
// Notes: supply and comparator levels arrive asynchronously
//
// Functional notes
// [RULE1] shutdown: all blocks off, outputs high impedance
// [RULE2] enter shutdown on analog supply arrival or io supply low
// [RULE3] io supply low forces shutdown from any mode, losing registers
// [RULE4] io supply high: startup, defaults loaded, serial on, boost on
// [RULE5] startup moves to active by itself
// [RULE6] startup command from active or low power reruns startup
// [RULE7] active command returns low power to active
// [RULE8] low power command moves active to low power
// [RULE9] low power: serial on, outputs high impedance, boost off
// [RULE10] registers kept through low power
// [RULE11] active: each output set or off by its own writes
// [RULE12] supply-on reset also resets serial interface logic
// [RULE13] supply-on reset needs io supply low then high again
// [RULE14] defaults: boost level 1011, state 01 then 00, mask 000
// [RULE15] shutdown to active within 250 us, 180 us typical
// [RULE16] boost switches while rail below level reference
// [RULE17] switching averages 2 MHz, spread 0.8 to 3.2 MHz; periods of 35 to 65 cycles here span about 1.54 to 2.86 MHz
// [RULE18] code 00h disables output and pulls it to ground
// [RULE19] level code selects 9 V to 24 V rail in 1 V steps
// [RULE20] serial writes ignored in shutdown, accepted from startup on
// [RULE21] disallowed power-state requests leave the mode unchanged
`timescale 1ns/1ps
module supply_mode_sequencer
	import supply_mode_pkg::*;
#(
	parameter int STARTUP_CYC = WAKE_TO_ACTIVE_TYP_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic ANALOG_SUPPLY_OK,
	input wire logic IO_SUPPLY_OK,
	input wire logic HV_BELOW_REF,
	input wire logic REG_WR,
	input wire logic [2:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [1:0] POWER_STATE,
	output logic SERIAL_ENABLE,
	output logic SERIAL_RST_B,
	output logic BOOST_ENABLE,
	output logic BOOST_SWITCH,
	output logic [3:0] BOOST_LEVEL,
	output logic [4:0] HV_TARGET_VOLTS,
	output logic [NUM_OUTPUTS-1:0] OUT_DRIVE,
	output logic [NUM_OUTPUTS-1:0] OUT_PULL_DOWN,
	output logic [8*NUM_OUTPUTS-1:0] OUT_CODE
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYC - 1);

	logic analog_ok;
	logic io_ok;
	logic hv_below;
	logic armed_reg;
	logic armed_next;
	mode_t mode_reg;
	mode_t mode_next;
	logic [15:0] wait_reg;
	logic [15:0] wait_next;
	logic [3:0] boost_level_reg;
	logic [2:0] mask_reg;
	logic [7:0] code_reg [NUM_OUTPUTS];
	logic spread_tick;

	wire supply_down;
	wire power_up;
	wire load_defaults;
	wire write_ok;
	wire [5:0] sel;
	wire ps_write;
	wire [1:0] ps_req;
	wire startup_done;
	wire boost_on;
	wire serial_on;
	wire [1:0] ps_view;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// one-hot decode of the write address
	function automatic logic [5:0] reg_decode(input logic wr,
		input logic [2:0] addr);
		logic [5:0] hit;
		hit = 6'h00;
		if (wr && addr <= IDX_TUNE_CODE_A + 3'h2) begin
			hit[addr] = 1'b1;
		end
		return hit;
	endfunction

	// power-state view of a mode
	function automatic logic [1:0] mode_code(input mode_t m);
		logic [1:0] c;
		c = PS_SHUTDOWN;
		case (m)
			MODE_STARTUP: c = PS_STARTUP;
			MODE_ACTIVE: c = PS_ACTIVE;
			MODE_LOW_POWER: c = PS_LOW_POWER;
			default: c = PS_SHUTDOWN;
		endcase
		return c;
	endfunction

	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	level_sync #(
		.W(3)
	) u_sync (
		.clk(SYS_CLK),
		.rst_b(RST_B),
		.d({ANALOG_SUPPLY_OK, IO_SUPPLY_OK, HV_BELOW_REF}),
		.q({analog_ok, io_ok, hv_below})
	);

	// ------------------------------------------------------------
	// supply tracking
	// ------------------------------------------------------------
	// either supply low overrides every other condition
	assign supply_down = !analog_ok || !io_ok; // [RULE2] [RULE3]

	// not a brown-out detector: a fresh low is needed to re-arm
	assign armed_next = supply_down ? 1'b1 : // [RULE13]
		(power_up ? 1'b0 : armed_reg);
	assign power_up = (mode_reg == MODE_SHUTDOWN) && !supply_down
		&& armed_reg; // [RULE4] [RULE13]

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	// no writes before startup has begun
	assign write_ok = (mode_reg != MODE_SHUTDOWN) && !supply_down; // [RULE20]
	assign sel = reg_decode(REG_WR && write_ok, REG_ADDR);
	assign ps_write = sel[IDX_POWER_STATE];
	assign ps_req = REG_WDATA[1:0];

	// ------------------------------------------------------------
	// mode sequencing
	// ------------------------------------------------------------
	assign startup_done = (wait_reg >= STARTUP_LAST); // [RULE15]
	assign load_defaults = power_up ||
		(mode_next == MODE_STARTUP && mode_reg != MODE_STARTUP); // [RULE4]

	always_comb begin
		// other requests fall through unchanged
		mode_next = mode_reg; // [RULE21]
		wait_next = wait_reg;
		case (mode_reg)
			MODE_SHUTDOWN: begin
				wait_next = 16'h0000;
				if (power_up) begin
					mode_next = MODE_STARTUP; // [RULE4]
				end
			end
			MODE_STARTUP: begin
				// power-state writes are not honoured here
				if (startup_done) begin
					mode_next = MODE_ACTIVE; // [RULE5] [RULE15]
					wait_next = 16'h0000;
				end else begin
					wait_next = wait_reg + 16'h0001;
				end
			end
			MODE_ACTIVE: begin
				wait_next = 16'h0000;
				if (ps_write && ps_req == PS_STARTUP) begin
					mode_next = MODE_STARTUP; // [RULE6]
				end else if (ps_write && ps_req == PS_LOW_POWER) begin
					mode_next = MODE_LOW_POWER; // [RULE8]
				end
			end
			MODE_LOW_POWER: begin
				wait_next = 16'h0000;
				if (ps_write && ps_req == PS_STARTUP) begin
					mode_next = MODE_STARTUP; // [RULE6]
				end else if (ps_write && ps_req == PS_ACTIVE) begin
					mode_next = MODE_ACTIVE; // [RULE7]
				end
			end
			default: begin
				mode_next = MODE_SHUTDOWN;
				wait_next = 16'h0000;
			end
		endcase
		// supply loss beats any request in the same cycle
		if (supply_down) begin
			mode_next = MODE_SHUTDOWN; // [RULE3]
			wait_next = 16'h0000;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			mode_reg <= MODE_SHUTDOWN; // [RULE2]
			wait_reg <= 16'h0000;
			armed_reg <= 1'b1;
		end else begin
			mode_reg <= mode_next;
			wait_reg <= wait_next;
			armed_reg <= armed_next;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// defaults on every startup entry; shutdown contents are lost anyway
	// low power leaves everything untouched
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			boost_level_reg <= BOOST_LEVEL_RST;
		end else if (load_defaults || supply_down) begin
			boost_level_reg <= BOOST_LEVEL_RST; // [RULE14] [RULE3]
		end else if (sel[IDX_BOOST_LEVEL]) begin
			boost_level_reg <= REG_WDATA[3:0]; // [RULE10]
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			mask_reg <= OUTPUT_ENABLE_MASK_RST;
		end else if (load_defaults || supply_down) begin
			mask_reg <= OUTPUT_ENABLE_MASK_RST; // [RULE14]
		end else if (sel[IDX_OUTPUT_ENABLE_MASK]) begin
			mask_reg <= REG_WDATA[2:0]; // [RULE11]
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_OUTPUTS; g++) begin : g_out
			wire code_hit;
			wire code_live;
			assign code_hit = sel[IDX_TUNE_CODE_A + 3'(g)];
			assign code_live = (code_reg[g] != TUNE_CODE_OFF); // [RULE18]

			always_ff @(posedge SYS_CLK or negedge RST_B) begin
				if (!RST_B) begin
					code_reg[g] <= TUNE_CODE_RST;
				end else if (load_defaults || supply_down) begin
					code_reg[g] <= TUNE_CODE_RST; // [RULE4]
				end else if (code_hit) begin
					code_reg[g] <= REG_WDATA; // [RULE11] [RULE10]
				end
			end

			// drive only in active; idle outputs there sink to ground
			always_ff @(posedge SYS_CLK or negedge RST_B) begin
				if (!RST_B) begin
					OUT_DRIVE[g] <= 1'b0;
					OUT_PULL_DOWN[g] <= 1'b0;
					OUT_CODE[8*g +: 8] <= TUNE_CODE_RST;
				end else if (mode_next == MODE_ACTIVE) begin
					OUT_DRIVE[g] <= mask_reg[g] && code_live; // [RULE11]
					OUT_PULL_DOWN[g] <= !(mask_reg[g] && code_live); // [RULE18]
					OUT_CODE[8*g +: 8] <= code_reg[g];
				end else begin
					OUT_DRIVE[g] <= 1'b0; // [RULE1] [RULE9]
					OUT_PULL_DOWN[g] <= 1'b0;
					OUT_CODE[8*g +: 8] <= code_reg[g];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// boost converter control
	// ------------------------------------------------------------
	assign boost_on = (mode_next == MODE_STARTUP) ||
		(mode_next == MODE_ACTIVE); // [RULE4] [RULE9] [RULE1]

	spread_clock_gen u_spread (
		.clk(SYS_CLK),
		.rst_b(RST_B),
		.run(boost_on),
		.tick(spread_tick)
	);

	// on/off regulation: hysteresis is left to the comparator
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			BOOST_ENABLE <= 1'b0;
			BOOST_SWITCH <= 1'b0;
			BOOST_LEVEL <= BOOST_LEVEL_RST;
			HV_TARGET_VOLTS <= HV_MIN_VOLTS + {1'b0, BOOST_LEVEL_RST};
		end else begin
			BOOST_ENABLE <= boost_on;
			BOOST_SWITCH <= boost_on && hv_below && spread_tick; // [RULE16]
			BOOST_LEVEL <= boost_level_reg;
			HV_TARGET_VOLTS <= HV_MIN_VOLTS + {1'b0, boost_level_reg}; // [RULE19]
		end
	end

	// ------------------------------------------------------------
	// serial interface control and status
	// ------------------------------------------------------------
	// serial reset held for shutdown and the startup entry cycle
	assign serial_on = (mode_next != MODE_SHUTDOWN); // [RULE9] [RULE20]
	assign ps_view = mode_code(mode_next);

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			SERIAL_ENABLE <= 1'b0;
			SERIAL_RST_B <= 1'b0;
			POWER_STATE <= PS_SHUTDOWN;
		end else begin
			SERIAL_ENABLE <= serial_on;
			SERIAL_RST_B <= serial_on && !load_defaults; // [RULE12]
			POWER_STATE <= ps_view; // [RULE14]
		end
	end

endmodule

/* verif/host_model.sv */
// Purpose: host model issuing register writes
// Assumes: launched at the falling edge
// Notes: one-cycle strobe, idle cycle between writes
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	output logic wr,
	output logic [2:0] addr,
	output logic [7:0] wdata
);
	initial begin
		wr = 1'b0;
		addr = 3'h7;
		wdata = 8'h00;
	end
	task automatic write(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 1'b0;
		// released lines must not keep the last value
		addr = ~a;
		wdata = ~d;
	endtask
endmodule

/* verif/supply_mode_sequencer_sva.sv */
// Purpose: port checker for the supply mode sequencer
// Assumes: one clock domain
// Notes: bound to the top module
`timescale 1ns/1ps
module supply_mode_sequencer_sva
	import supply_mode_pkg::*;
#(
	parameter int STARTUP_CYC = WAKE_TO_ACTIVE_TYP_CYC
) (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic IO_SUPPLY_OK,
	input wire logic REG_WR,
	input wire logic [2:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [1:0] POWER_STATE,
	input wire logic SERIAL_ENABLE,
	input wire logic SERIAL_RST_B,
	input wire logic BOOST_ENABLE,
	input wire logic BOOST_SWITCH,
	input wire logic [3:0] BOOST_LEVEL,
	input wire logic [4:0] HV_TARGET_VOLTS,
	input wire logic [2:0] OUT_DRIVE,
	input wire logic [2:0] OUT_PULL_DOWN,
	input wire logic [23:0] OUT_CODE
);
	logic [15:0] st_cnt;
	// counter, since startup is too long to unroll
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_cnt <= 16'h0000;
		end else begin
			st_cnt <= (POWER_STATE == 2'h1) ? st_cnt + 16'h0001 : 16'h0000;
		end
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	a_shutdown_all_off: assert property (
		POWER_STATE == 2'h3 |-> !SERIAL_ENABLE && !BOOST_ENABLE
		&& OUT_DRIVE == 3'h0 && OUT_PULL_DOWN == 3'h0)
		else $error("outputs active in shutdown");
	a_io_low_shutdown: assert property (
		$fell(IO_SUPPLY_OK) |-> ##[1:6] POWER_STATE == 2'h3)
		else $error("no shutdown after io supply loss");
	a_startup_hiz: assert property (
		POWER_STATE == 2'h1 |-> SERIAL_ENABLE && BOOST_ENABLE
		&& OUT_DRIVE == 3'h0 && OUT_PULL_DOWN == 3'h0)
		else $error("startup outputs wrong");
	a_serial_reset_pulse: assert property (
		$rose(POWER_STATE == 2'h1) |-> !SERIAL_RST_B ##1 SERIAL_RST_B)
		else $error("serial reset not pulsed");
	a_startup_bound: assert property (
		st_cnt <= 16'(STARTUP_CYC + 4))
		else $error("startup too long");
	a_startup_min: assert property (
		$fell(POWER_STATE == 2'h1) && POWER_STATE == 2'h0
		|-> $past(st_cnt) >= 16'(STARTUP_CYC - 2))
		else $error("startup too short");
	a_lp_outputs_off: assert property (
		POWER_STATE == 2'h2 |-> SERIAL_ENABLE && !BOOST_ENABLE
		&& OUT_DRIVE == 3'h0 && OUT_PULL_DOWN == 3'h0)
		else $error("low power outputs wrong");
	a_hv_target_map: assert property (
		HV_TARGET_VOLTS == {1'b0, BOOST_LEVEL} + 5'h09)
		else $error("rail target mismatch");
	a_zero_code_pull: assert property (
		POWER_STATE == 2'h0 && OUT_CODE[7:0] == 8'h00
		|-> OUT_PULL_DOWN[0] && !OUT_DRIVE[0])
		else $error("zero code not pulled down");
	a_lp_request: assert property (
		REG_WR && REG_ADDR == 3'h1 && REG_WDATA[1:0] == 2'h2
		&& POWER_STATE == 2'h0 |-> ##2 POWER_STATE == 2'h2)
		else $error("low power not entered");
	a_bad_request: assert property (
		REG_WR && REG_ADDR == 3'h1 && REG_WDATA[1:0] == 2'h3
		&& POWER_STATE == 2'h0 |-> ##2 POWER_STATE == 2'h0)
		else $error("disallowed request changed mode");
	a_switch_gap: assert property (
		BOOST_SWITCH |=> !BOOST_SWITCH [*8])
		else $error("switching too fast");
	a_switch_gated: assert property (
		BOOST_SWITCH |-> BOOST_ENABLE || $past(BOOST_ENABLE))
		else $error("switching while boost off");
endmodule
bind supply_mode_sequencer supply_mode_sequencer_sva #(
	.STARTUP_CYC(STARTUP_CYC)
) u_sva (
	.SYS_CLK(SYS_CLK), .RST_B(RST_B), .IO_SUPPLY_OK(IO_SUPPLY_OK),
	.REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.POWER_STATE(POWER_STATE), .SERIAL_ENABLE(SERIAL_ENABLE),
	.SERIAL_RST_B(SERIAL_RST_B), .BOOST_ENABLE(BOOST_ENABLE),
	.BOOST_SWITCH(BOOST_SWITCH), .BOOST_LEVEL(BOOST_LEVEL),
	.HV_TARGET_VOLTS(HV_TARGET_VOLTS), .OUT_DRIVE(OUT_DRIVE),
	.OUT_PULL_DOWN(OUT_PULL_DOWN), .OUT_CODE(OUT_CODE)
);

/* verif/supply_mode_sequencer_test.sv */
// Purpose: self-checking bench for the supply mode sequencer
// Assumes: short startup count for simulation
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
module supply_mode_sequencer_test
	import supply_mode_pkg::*;
;
	localparam int SCYC = 20;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic analog_ok, io_ok, hv_below, wr;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic [1:0] ps;
	logic ser_en, ser_rst_b, boost_en, boost_sw;
	logic [3:0] lvl;
	logic [4:0] hv_v;
	logic [2:0] drv, pull;
	logic [23:0] code;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	int n;
	host_model u_host (.clk(sys_clk), .wr(wr), .addr(addr), .wdata(wdata));
	supply_mode_sequencer #(
		.STARTUP_CYC(SCYC)
	) u_dut (
		.SYS_CLK(sys_clk), .RST_B(rst_b), .ANALOG_SUPPLY_OK(analog_ok),
		.IO_SUPPLY_OK(io_ok), .HV_BELOW_REF(hv_below), .REG_WR(wr),
		.REG_ADDR(addr), .REG_WDATA(wdata), .POWER_STATE(ps),
		.SERIAL_ENABLE(ser_en), .SERIAL_RST_B(ser_rst_b),
		.BOOST_ENABLE(boost_en), .BOOST_SWITCH(boost_sw),
		.BOOST_LEVEL(lvl), .HV_TARGET_VOLTS(hv_v), .OUT_DRIVE(drv),
		.OUT_PULL_DOWN(pull), .OUT_CODE(code)
	);
	always #5 sys_clk = ~sys_clk;
	// ceiling well above the several hundred cycles the run needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (fail_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [23:0] e,
		input logic [23:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wait_ps(input logic [1:0] e, input int lim);
		for (int i = 0; i < lim && ps !== e; i++) begin
			@(negedge sys_clk);
		end
		chk("power_state", 24'(e), 24'(ps));
	endtask
	// outputs settle two edges after the strobe
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		u_host.write(a, d);
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic count_sw(input int len, output int c);
		c = 0;
		repeat (len) begin
			@(negedge sys_clk);
			c += int'(boost_sw);
		end
	endtask
	initial begin
		analog_ok = 1'b0;
		io_ok = 1'b0;
		hv_below = 1'b0;
		repeat (4) @(negedge sys_clk);
		rst_b = 1'b1;
		@(negedge sys_clk);
		chk("ps_reset", 24'(PS_SHUTDOWN), 24'(ps));
		chk("off", 24'h0, 24'({ser_en, boost_en, drv, pull}));
		analog_ok = 1'b1;
		io_ok = 1'b1;
		wait_ps(PS_STARTUP, 8);
		chk("start", 24'hc0, 24'({ser_en, boost_en, drv, pull}));
		chk("level", 24'(BOOST_LEVEL_RST), 24'(lvl));
		wait_ps(PS_ACTIVE, SCYC + 8);
		chk("code", 24'h0, code);
		chk("drive", 24'h0, 24'(drv));
		hv_below = 1'b1;
		repeat (5) @(negedge sys_clk);
		count_sw(400, n);
		chk("sw_rate", 24'h1, 24'(n >= 6 && n <= 12));
		hv_below = 1'b0;
		repeat (5) @(negedge sys_clk);
		count_sw(100, n);
		chk("sw_idle", 24'h0, 24'(n));
		wr_reg(IDX_BOOST_LEVEL, 8'h03);
		chk("level", 24'h3, 24'(lvl));
		chk("volts", 24'(HV_MIN_VOLTS + 5'h03), 24'(hv_v));
		wr_reg(IDX_TUNE_CODE_A, 8'h40);
		wr_reg(3'h4, 8'h00);
		wr_reg(3'h5, 8'h10);
		wr_reg(IDX_OUTPUT_ENABLE_MASK, 8'h07);
		chk("drive", 24'h5, 24'(drv));
		chk("pull", 24'h2, 24'(pull));
		wr_reg(IDX_OUTPUT_ENABLE_MASK, 8'h06);
		chk("drive", 24'h4, 24'(drv));
		chk("pull", 24'h3, 24'(pull));
		wr_reg(3'h6, 8'hff);
		chk("code", 24'h100040, code);
		wr_reg(IDX_POWER_STATE, 8'h03);
		chk("ps_bad", 24'(PS_ACTIVE), 24'(ps));
		wr_reg(IDX_POWER_STATE, 8'h02);
		chk("ps_lp", 24'(PS_LOW_POWER), 24'(ps));
		chk("lp", 24'h80, 24'({ser_en, boost_en, drv, pull}));
		wr_reg(IDX_POWER_STATE, 8'h02);
		chk("ps_lp", 24'(PS_LOW_POWER), 24'(ps));
		wr_reg(IDX_POWER_STATE, 8'h00);
		chk("ps_act", 24'(PS_ACTIVE), 24'(ps));
		chk("level", 24'h3, 24'(lvl));
		chk("code", 24'h100040, code);
		chk("drive", 24'h4, 24'(drv));
		wr_reg(IDX_POWER_STATE, 8'h01);
		wait_ps(PS_STARTUP, 4);
		chk("level", 24'(BOOST_LEVEL_RST), 24'(lvl));
		wait_ps(PS_ACTIVE, SCYC + 8);
		chk("code", 24'h0, code);
		wr_reg(IDX_BOOST_LEVEL, 8'h05);
		io_ok = 1'b0;
		wait_ps(PS_SHUTDOWN, 8);
		chk("off", 24'h0, 24'({ser_en, boost_en, drv, pull}));
		wr_reg(IDX_POWER_STATE, 8'h00);
		chk("ps_sd", 24'(PS_SHUTDOWN), 24'(ps));
		io_ok = 1'b1;
		wait_ps(PS_STARTUP, 8);
		chk("level", 24'(BOOST_LEVEL_RST), 24'(lvl));
		tally_and_finish();
	end
endmodule
